// ==== rtl/marker_detector.sv ====
// Detector for the low-run then high-run marker on the channel-0 sample LSB
`timescale 1ns/1ps
`default_nettype none
`include "nco_sync_params.svh"
module marker_detector
    import nco_sync_pkg::*;
(
    input  wire logic clk,       // Sample clock
    input  wire logic arst_n,    // Asynchronous reset, active low
    input  wire logic enable,    // Watch the marker while high
    input  wire logic lsb_in,    // Channel-0 I sample LSB
    output logic      hit,       // Fourth high sample seen
    output logic      waiting    // Detector is hunting for the marker
);
    typedef struct packed {
        marker_state_type state;
        logic [2:0]       count;
    } det_type;

    det_type st_reg;
    det_type st_next;

    // Low run arms, then four highs fire; hit is combinational so it is coincident
    always_comb begin
        st_next = st_reg;
        hit = 1'b0;
        if (!enable) begin
            st_next.state = MARK_IDLE;
            st_next.count = 3'h0;
        end else begin
            unique case (st_reg.state)
                MARK_IDLE: begin
                    st_next.state = MARK_LOW;
                    st_next.count = lsb_in ? 3'h0 : 3'h1;
                end
                MARK_LOW: begin
                    if (!lsb_in) begin
                        if (st_reg.count != `MARKER_RUN_LENGTH) begin
                            st_next.count = st_reg.count + 3'h1;
                        end
                    end else if (st_reg.count == `MARKER_RUN_LENGTH) begin // RULE4
                        st_next.state = MARK_HIGH;
                        st_next.count = 3'h1;
                    end else begin
                        st_next.count = 3'h0;
                    end
                end
                MARK_HIGH: begin
                    if (!lsb_in) begin
                        st_next.state = MARK_LOW;
                        st_next.count = 3'h1;
                    end else if (st_reg.count == `MARKER_RUN_LENGTH - 3'h1) begin
                        hit = 1'b1; // RULE5
                        st_next.state = MARK_LOW;
                        st_next.count = 3'h0;
                    end else begin
                        st_next.count = st_reg.count + 3'h1;
                    end
                end
                default: begin
                    st_next.state = MARK_IDLE;
                    st_next.count = 3'h0;
                end
            endcase
        end
    end

    assign waiting = enable;

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{state: MARK_IDLE, count: 3'h0};
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/nco_sync_control.sv ====
// Sync event control for the four up-converter oscillators
// Functional notes
// RULE1: Reconfig mode events reset reconfig-masked accumulators and apply pending reconfig values.
// RULE2: Reconfig mode, source 0, select set: event at chip select rising edge.
// RULE3: Reconfig mode sources 1 and 2 are reserved and make no events.
// RULE4: Source 3 marker: four or more lows arm, then four highs required.
// RULE5: Marker event fires in the cycle of the fourth high sample.
// RULE6: While hunting the marker, the LSB is zeroed; data resumes right after; in normal mode the code keeps zeroing it while the software bit is high.
// RULE7: Host changes trigger source only with software bit 0 and chip select high; the code takes source writes at any time.
// RULE8: Accumulator mask bit n clears oscillator n on events; ignored in reconfig mode.
// RULE9: Accumulator reset mask resets to 0x0f.
// RULE10: Writing 1 over 0 to software sync triggers; ignored in reconfig mode.
// RULE11: Software sync register reads back the last written value, never self-clears.
// RULE12: Software sync is edge or level sensitive per trigger source.
// RULE13: Normal mode source 0: software set gives an event at once.
// RULE14: Normal mode source 1: software set arms an event at next SYSREF rise.
// RULE15: Normal mode source 2: event on every SYSREF rise while bit is high.
// RULE16: Normal mode source 3: marker triggers events while software bit is high.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "nco_sync_params.svh"
module nco_sync_control
    import nco_sync_pkg::*;
(
    input  wire logic         clk,                       // Sample clock, 20 MHz
    input  wire logic         arst_n,                    // Asynchronous reset, active low
    input  wire logic [11:0]  reg_addr,                  // Register address
    input  wire logic [7:0]   reg_wdata,                 // Register write data
    input  wire logic         reg_write,                 // Write strobe
    input  wire logic         reg_read,                  // Read strobe
    output logic      [7:0]   reg_rdata,                 // Read data, cycle after strobe
    input  wire logic         fast_reconfig_enable,      // Fast reconfiguration mode
    input  wire logic         reconfig_sync_select,      // Reconfig sync select
    input  wire logic         reconfig_chip_select,      // Reconfig chip select pin
    input  wire logic [3:0]   reconfig_accum_reset_mask, // Reconfig accumulator mask
    input  wire logic         sysref,                    // SYSREF pin
    input  wire logic [15:0]  channel0_i_in,             // Channel-0 I sample in
    output logic      [15:0]  channel0_i_out,            // Channel-0 I sample to converter
    output logic              sync_event,                // One-cycle sync event
    output logic      [3:0]   accum_reset,               // Accumulators cleared this cycle
    output logic              apply_reconfig             // Apply pending reconfig values
);
    typedef struct packed {
        logic [7:0]   accum_ctrl;
        logic [7:0]   soft_sync;
        logic [7:0]   source;
        logic [7:0]   rdata;
        logic [1:0]   sysref_sync;
        logic         sysref_last;
        logic [1:0]   cs_sync;
        logic         cs_last;
        logic         sysref_armed;
        logic         marker_armed;
        logic [15:0]  sample;
        sync_out_type out;
    } state_type;

    state_type st_reg;
    state_type st_next;
    reg_req_type req;
    logic marker_hit;
    logic marker_waiting;
    logic marker_enable;

    assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write, read: reg_read};

    marker_detector u_marker (
        .clk     (clk),
        .arst_n  (arst_n),
        .enable  (marker_enable),
        .lsb_in  (channel0_i_in[0]),
        .hit     (marker_hit),
        .waiting (marker_waiting)
    );

    // Marker hunt is live in reconfig mode after a chip select rise, or in normal mode while bit set
    assign marker_enable = (st_reg.source[1:0] == SRC_MARKER) &&
        (fast_reconfig_enable ? st_reg.marker_armed
                              : st_reg.soft_sync[`SOFTWARE_SYNC_BIT]); // RULE16

    // Next state: registers, edge detection, trigger selection
    always_comb begin
        logic soft_rise;
        logic sysref_rise;
        logic cs_rise;
        logic fire;
        source_type src;
        soft_rise = 1'b0;
        sysref_rise = 1'b0;
        cs_rise = 1'b0;
        fire = 1'b0;
        src = source_type'(st_reg.source[`SOURCE_MSB:0]);
        st_next = st_reg;

        // Pin inputs pass two flops before any logic reads them
        st_next.sysref_sync = {st_reg.sysref_sync[0], sysref};
        st_next.cs_sync = {st_reg.cs_sync[0], reconfig_chip_select};
        st_next.sysref_last = st_reg.sysref_sync[1];
        st_next.cs_last = st_reg.cs_sync[1];
        sysref_rise = st_reg.sysref_sync[1] && !st_reg.sysref_last;
        cs_rise = st_reg.cs_sync[1] && !st_reg.cs_last;

        // Register writes; the software bit holds its written value
        if (req.write) begin
            unique case (req.addr)
                `ACCUM_RESET_CONTROL_OFFSET: st_next.accum_ctrl = {4'h0, req.wdata[3:0]};
                `SOFTWARE_SYNC_TRIGGER_OFFSET: begin
                    st_next.soft_sync = {7'h00, req.wdata[`SOFTWARE_SYNC_BIT]}; // RULE11
                    soft_rise = req.wdata[`SOFTWARE_SYNC_BIT] &&
                        !st_reg.soft_sync[`SOFTWARE_SYNC_BIT]; // RULE10
                end
                `SYNC_TRIGGER_SOURCE_OFFSET: st_next.source = {6'h00, req.wdata[1:0]}; // RULE7
                default: ;
            endcase
        end

        // Register reads, data stands one cycle later; unmapped reads return zero
        st_next.rdata = 8'h00;
        if (req.read) begin
            unique case (req.addr)
                `ACCUM_RESET_CONTROL_OFFSET: st_next.rdata = st_reg.accum_ctrl;
                `SOFTWARE_SYNC_TRIGGER_OFFSET: st_next.rdata = st_reg.soft_sync;
                `SYNC_TRIGGER_SOURCE_OFFSET: st_next.rdata = st_reg.source;
                default: st_next.rdata = 8'h00;
            endcase
        end

        if (fast_reconfig_enable) begin
            // Software bit ignored in reconfig mode
            st_next.sysref_armed = 1'b0; // RULE10
            unique case (src)
                SRC_IMMEDIATE: fire = reconfig_sync_select && cs_rise; // RULE2
                SRC_SYSREF_ONCE, SRC_SYSREF_EVERY: fire = 1'b0; // RULE3
                SRC_MARKER: begin
                    // A new chip select rise in the hit cycle re-arms: the set wins
                    if (marker_hit) begin
                        fire = 1'b1; // RULE5
                        st_next.marker_armed = 1'b0;
                    end
                    if (reconfig_sync_select && cs_rise) begin
                        st_next.marker_armed = 1'b1; // RULE4
                    end
                end
            endcase
        end else begin
            st_next.marker_armed = 1'b0;
            // Edge or level use of the software bit by source
            unique case (src) // RULE12
                SRC_IMMEDIATE: fire = soft_rise; // RULE13
                SRC_SYSREF_ONCE: begin
                    if (soft_rise) begin
                        st_next.sysref_armed = 1'b1; // RULE14
                    end
                    if (st_reg.sysref_armed && sysref_rise) begin
                        fire = 1'b1;
                        st_next.sysref_armed = soft_rise;
                    end
                end
                SRC_SYSREF_EVERY: fire = st_reg.soft_sync[`SOFTWARE_SYNC_BIT] && sysref_rise; // RULE15
                SRC_MARKER: fire = marker_hit; // RULE16
            endcase
            if (src != SRC_SYSREF_ONCE) begin
                st_next.sysref_armed = 1'b0;
            end
        end

        // Event outputs: mask source depends on mode
        st_next.out.sync_event = fire;
        st_next.out.apply_reconfig = fire && fast_reconfig_enable; // RULE1
        st_next.out.accum_reset = !fire ? 4'h0 :
            fast_reconfig_enable ? reconfig_accum_reset_mask   // RULE1
                                 : st_reg.accum_ctrl[`ACCUM_MASK_MSB:0]; // RULE8

        // LSB is zeroed while hunting; the hit sample itself carries data again
        st_next.sample = channel0_i_in;
        if (marker_waiting && !marker_hit) begin
            st_next.sample[0] = 1'b0; // RULE6
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.accum_ctrl <= `ACCUM_RESET_CONTROL_RESET; // RULE9
            st_reg.soft_sync <= `SOFTWARE_SYNC_TRIGGER_RESET;
            st_reg.source <= `SYNC_TRIGGER_SOURCE_RESET;
            st_reg.sysref_sync <= 2'h0;
            st_reg.cs_sync <= 2'h3;
            st_reg.cs_last <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from flops
    assign reg_rdata = st_reg.rdata;
    assign channel0_i_out = st_reg.sample;
    assign sync_event = st_reg.out.sync_event;
    assign accum_reset = st_reg.out.accum_reset;
    assign apply_reconfig = st_reg.out.apply_reconfig;
endmodule
`default_nettype wire

// ==== rtl/nco_sync_params.svh ====
// Offsets, field positions, reset values and timing counts of the oscillator sync block
`ifndef NCO_SYNC_PARAMS_SVH
`define NCO_SYNC_PARAMS_SVH
`define ACCUM_RESET_CONTROL_OFFSET 12'h303
`define SOFTWARE_SYNC_TRIGGER_OFFSET 12'h304
`define SYNC_TRIGGER_SOURCE_OFFSET 12'h302
`define ACCUM_RESET_CONTROL_RESET 8'h0f
`define SOFTWARE_SYNC_TRIGGER_RESET 8'h00
`define SYNC_TRIGGER_SOURCE_RESET 8'h00
`define SOFTWARE_SYNC_BIT 0
`define ACCUM_MASK_MSB 3
`define SOURCE_MSB 1
`define MARKER_RUN_LENGTH 3'h4
`endif

// ==== rtl/nco_sync_pkg.sv ====
// Types shared by the oscillator sync control block
package nco_sync_pkg;
    typedef enum logic [1:0] {
        SRC_IMMEDIATE,
        SRC_SYSREF_ONCE,
        SRC_SYSREF_EVERY,
        SRC_MARKER
    } source_type;

    typedef enum logic [1:0] {
        MARK_IDLE,
        MARK_LOW,
        MARK_HIGH
    } marker_state_type;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        read;
    } reg_req_type;

    // Sync event outputs toward the oscillators
    typedef struct packed {
        logic       sync_event;
        logic [3:0] accum_reset;
        logic       apply_reconfig;
    } sync_out_type;
endpackage

// ==== verification/nco_sync_control_assertions.sv ====
// Port-level checks of the oscillator sync control block
`timescale 1ns/1ps
`default_nettype none
module nco_sync_control_checker (
    input wire logic        clk,                       // Clock
    input wire logic        arst_n,                    // Reset
    input wire logic [11:0] reg_addr,                  // Address
    input wire logic [7:0]  reg_wdata,                 // Write data
    input wire logic        reg_write,                 // Write strobe
    input wire logic        reg_read,                  // Read strobe
    input wire logic [7:0]  reg_rdata,                 // Read data
    input wire logic        fast_reconfig_enable,      // Reconfig mode
    input wire logic        reconfig_sync_select,      // Sync select
    input wire logic        reconfig_chip_select,      // Chip select
    input wire logic [3:0]  reconfig_accum_reset_mask, // Reconfig mask
    input wire logic        sysref,                    // SYSREF pin
    input wire logic [15:0] channel0_i_out,            // Sample out
    input wire logic        sync_event,                // Event
    input wire logic [3:0]  accum_reset,               // Cleared set
    input wire logic        apply_reconfig             // Apply pulse
);
    logic [1:0] src_reg;
    logic [3:0] mask_reg;
    logic       soft_reg;
    logic       soft_rise;
    // Shadow copies of the register fields that steer events
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_reg <= 2'h0;
            mask_reg <= 4'hf;
            soft_reg <= 1'h0;
        end else if (reg_write) begin
            if (reg_addr == 12'h302) src_reg <= reg_wdata[1:0];
            if (reg_addr == 12'h303) mask_reg <= reg_wdata[3:0];
            if (reg_addr == 12'h304) soft_reg <= reg_wdata[0];
        end
    end
    assign soft_rise = reg_write && reg_addr == 12'h304 && reg_wdata[0] && !soft_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Pin edges pass a two-stage synchroniser before the event
    sequence s_late;
        ##[3:5] sync_event;
    endsequence
    property p_apply;
        apply_reconfig |-> sync_event && accum_reset == $past(reconfig_accum_reset_mask);
    endproperty
    a_apply: assert property (p_apply) else $error("Bad apply pulse");
    property p_mask;
        sync_event && !fast_reconfig_enable |-> accum_reset == mask_reg;
    endproperty
    a_mask: assert property (p_mask) else $error("Bad accumulator set");
    property p_now;
        !fast_reconfig_enable && src_reg == 2'h0 && soft_rise |=> sync_event;
    endproperty
    a_now: assert property (p_now) else $error("No immediate event");
    property p_reserved;
        fast_reconfig_enable && ^src_reg |=> !sync_event;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved source fired");
    property p_read;
        reg_read && reg_addr == 12'h304 |=> reg_rdata == {7'h00, soft_reg};
    endproperty
    a_read: assert property (p_read) else $error("Bad sync readback");
    property p_hunt;
        !fast_reconfig_enable && src_reg == 2'h3 && soft_reg && $past(soft_reg) && !sync_event
            |-> !channel0_i_out[0];
    endproperty
    a_hunt: assert property (p_hunt) else $error("Bit kept while hunting");
    property p_sysref;
        !fast_reconfig_enable && src_reg == 2'h2 && soft_reg && $rose(sysref) |-> s_late;
    endproperty
    a_sysref: assert property (p_sysref) else $error("No SYSREF event");
    property p_cs;
        fast_reconfig_enable && reconfig_sync_select && src_reg == 2'h0
            && $rose(reconfig_chip_select) |-> s_late;
    endproperty
    a_cs: assert property (p_cs) else $error("No chip select event");
endmodule
bind nco_sync_control nco_sync_control_checker checker_i (
    .clk                       (clk),
    .arst_n                    (arst_n),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_write                 (reg_write),
    .reg_read                  (reg_read),
    .reg_rdata                 (reg_rdata),
    .fast_reconfig_enable      (fast_reconfig_enable),
    .reconfig_sync_select      (reconfig_sync_select),
    .reconfig_chip_select      (reconfig_chip_select),
    .reconfig_accum_reset_mask (reconfig_accum_reset_mask),
    .sysref                    (sysref),
    .channel0_i_out            (channel0_i_out),
    .sync_event                (sync_event),
    .accum_reset               (accum_reset),
    .apply_reconfig            (apply_reconfig)
);
`default_nettype wire

// ==== verification/nco_sync_control_bench.sv ====
// Self-checking bench for the oscillator sync control block
`timescale 1ns/1ps
`default_nettype none
module nco_sync_control_bench;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        fast_reconfig_enable = 1'b0;
    logic        reconfig_sync_select = 1'b1;
    logic [3:0]  reconfig_accum_reset_mask = 4'h9;
    logic [15:0] channel0_i_in = 16'h0000;
    logic        sysref_go = 1'b0;
    logic        cs_go = 1'b0;
    logic        sysref, reconfig_chip_select, sync_event, apply_reconfig;
    logic [7:0]  reg_rdata;
    logic [3:0]  accum_reset;
    logic [15:0] channel0_i_out;
    logic [15:0] events = 16'h0000;
    logic [15:0] last_out;
    logic [4:0]  last_ev;
    int          errors = 0;
    int          samples_checked = 0;
    nco_sync_control dut (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_write                 (reg_write),
        .reg_read                  (reg_read),
        .reg_rdata                 (reg_rdata),
        .fast_reconfig_enable      (fast_reconfig_enable),
        .reconfig_sync_select      (reconfig_sync_select),
        .reconfig_chip_select      (reconfig_chip_select),
        .reconfig_accum_reset_mask (reconfig_accum_reset_mask),
        .sysref                    (sysref),
        .channel0_i_in             (channel0_i_in),
        .channel0_i_out            (channel0_i_out),
        .sync_event                (sync_event),
        .accum_reset               (accum_reset),
        .apply_reconfig            (apply_reconfig)
    );
    sync_pin_driver pins (
        .clk                  (clk),
        .sysref_go            (sysref_go),
        .cs_go                (cs_go),
        .sysref               (sysref),
        .reconfig_chip_select (reconfig_chip_select)
    );
    // Clock of 50 ns
    initial begin
        forever #25 clk = ~clk;
    end
    // Capture every sync pulse
    always @(posedge clk) begin
        if (sync_event === 1'b1) begin
            events <= events + 16'h1;
            last_ev <= {apply_reconfig, accum_reset};
            last_out <= channel0_i_out;
        end
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic put(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic get(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("read", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic kick(input logic s, input logic c);
        @(posedge clk);
        sysref_go <= s;
        cs_go <= c;
        @(posedge clk);
        sysref_go <= 1'b0;
        cs_go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic feed(input logic b, input int n);
        repeat (n) begin
            @(posedge clk);
            channel0_i_in <= {channel0_i_in[15:1] + 15'h1, b};
        end
    endtask
    // Low run, broken high run, low run, then a full high run
    task automatic mark(input logic [15:0] n, input logic l);
        feed(1'b0, 5);
        feed(1'b1, 3);
        feed(1'b0, 4);
        feed(1'b1, 2);
        #1 chk("hunt lsb", 16'h0000, {15'h0, channel0_i_out[0]});
        chk("events", n - 16'h1, events);
        feed(1'b1, 2);
        repeat (3) @(posedge clk);
        // Look after the edge so the registered sample has settled
        #1 chk("events", n, events);
        chk("hit sample", channel0_i_in, last_out);
        chk("lsb after", {15'h0, l}, {15'h0, channel0_i_out[0]});
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        get(12'h303, 8'h0f);
        get(12'h304, 8'h00);
        get(12'h3ff, 8'h00);
        put(12'h303, 8'hf5);
        get(12'h303, 8'h05);
        put(12'h304, 8'h01);
        chk("normal set", 16'h0005, {11'h0, last_ev});
        put(12'h304, 8'h01);
        get(12'h304, 8'h01);
        put(12'h304, 8'h00);
        chk("events", 16'h1, events);
        put(12'h302, 8'h01);
        get(12'h302, 8'h01);
        put(12'h304, 8'h01);
        chk("events", 16'h1, events);
        kick(1'b1, 1'b0);
        kick(1'b1, 1'b0);
        chk("events", 16'h2, events);
        put(12'h304, 8'h00);
        put(12'h302, 8'h02);
        put(12'h304, 8'h01);
        kick(1'b1, 1'b0);
        kick(1'b1, 1'b0);
        chk("events", 16'h4, events);
        put(12'h304, 8'h00);
        kick(1'b1, 1'b0);
        chk("events", 16'h4, events);
        put(12'h302, 8'h03);
        put(12'h304, 8'h01);
        mark(16'h5, 1'b0);
        put(12'h304, 8'h00);
        put(12'h302, 8'h00);
        fast_reconfig_enable <= 1'b1;
        kick(1'b0, 1'b1);
        chk("events", 16'h6, events);
        chk("reconfig set", 16'h0019, {11'h0, last_ev});
        put(12'h304, 8'h01);
        put(12'h304, 8'h00);
        chk("events", 16'h6, events);
        put(12'h302, 8'h01);
        kick(1'b0, 1'b1);
        put(12'h302, 8'h02);
        kick(1'b0, 1'b1);
        chk("events", 16'h6, events);
        put(12'h302, 8'h03);
        kick(1'b0, 1'b1);
        mark(16'h7, 1'b1);
        close_out;
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        close_out;
    end
endmodule
`default_nettype wire

// ==== verification/sync_pin_driver.sv ====
// Host pin model: SYSREF pulses and reconfig chip select frames
`timescale 1ns/1ps
`default_nettype none
module sync_pin_driver (
    input  wire logic clk,                 // Clock
    input  wire logic sysref_go,           // SYSREF request
    input  wire logic cs_go,               // Frame request
    output logic      sysref,              // SYSREF pin
    output logic      reconfig_chip_select // Chip select
);
    logic [1:0] sr_reg = 2'h0;
    logic [1:0] cs_reg = 2'h0;
    // Each request holds its pin active for three cycles
    always_ff @(posedge clk) begin
        sr_reg <= sysref_go ? 2'h3 : sr_reg - {1'b0, sr_reg != 2'h0};
        cs_reg <= cs_go ? 2'h3 : cs_reg - {1'b0, cs_reg != 2'h0};
    end
    assign sysref = sr_reg != 2'h0;
    assign reconfig_chip_select = cs_reg == 2'h0;
endmodule
`default_nettype wire
